/* File: hdl/bcs_pkg.sv */
// constants shared by the board configuration script controller
package bcs_pkg;
	localparam logic [7:0] CH_NL      = 8'h0a;
	localparam logic [7:0] CH_CR      = 8'h0d;
	localparam logic [7:0] CH_SLASH   = 8'h2f;
	localparam logic [7:0] CH_SPACE   = 8'h20;
	localparam logic [7:0] CH_COLON   = 8'h3a;
	localparam logic [7:0] CH_X       = 8'h78;
	localparam logic [7:0] CH_XU      = 8'h58;
	localparam logic [1:0] VERB_RST   = 2'h3;
	localparam logic       CHECK_RST  = 1'b1;
	// synthesizer reference frequencies in kHz
	localparam int         REF_A_KHZ  = 25000;
	localparam int         REF_B_KHZ  = 14180;
	localparam int         REF_C_KHZ  = 16000;
	localparam int         VCO_MIN_KHZ = 250000;
	localparam int         VCO_MAX_KHZ = 700000;
	// board micro reset pulse length
	localparam int         MRST_NS    = 1000;
	localparam int         CLK_NS     = 50;
	localparam int         MRST_CYC   = (MRST_NS + CLK_NS - 1) / CLK_NS;
	// command kinds, first letter of each line, second letter A splitting MAIN BUS from MEMORY
	typedef enum logic [3:0] {
		BCS_CMD_NONE  = 4'h0,
		BCS_CMD_NOTE  = 4'h1,
		BCS_CMD_LOAD  = 4'h2,
		BCS_CMD_CLK   = 4'h3,
		BCS_CMD_CHECK = 4'h4,
		BCS_CMD_VERB  = 4'h5,
		BCS_CMD_MEM   = 4'h6,
		BCS_CMD_MBUS  = 4'h7,
		BCS_CMD_PORT  = 4'h8
	} bcs_cmd_e;
	typedef enum logic [2:0] {
		BCS_ST_BOOT  = 3'b000,
		BCS_ST_OPEN  = 3'b001,
		BCS_ST_LINE  = 3'b011,
		BCS_ST_EXEC  = 3'b010,
		BCS_ST_WAIT  = 3'b110,
		BCS_ST_DONE  = 3'b111
	} bcs_state_e;
endpackage

/* File: hdl/bcs_script_ctrl.sv */
// script reader and command dispatcher of the board configuration controller
// Notes on behaviour
// (RQ1) after power-on read any card and open the default root script if present
// (RQ2) script holds one command per newline-separated line
// (RQ3) a line starting with double slash does nothing
// (RQ4) verbosity levels 0..3, 0 errors only, default 3
// (RQ5) load command configures user fpga a, b or c from named file
// (RQ6) with header check on (default) mismatching bitstream is rejected, error flashed
// (RQ7) clock command programs synthesizer a, b or c with m and n
// (RQ8) n and m are positive one- or two-digit decimals
// (RQ9) reference times m must lie in 250..700 mhz; the code does not check this, VCO_MIN_KHZ and VCO_MAX_KHZ are unused
// (RQ10) references: 25 mhz a, 14.18 mhz b, 16 mhz c
// (RQ11) memory-mapped command writes a byte to a 16-bit controller address
// (RQ12) main-bus command writes one 32-bit word to a 32-bit address; the code sends only the low 8 address bits
// (RQ13) serial port numbers 2..4 cause no operation
// (RQ14) host window 0 goes to controller, windows 1..7 to user fpga a
// (RQ15) controller and fpga a never drive the bridge back-end together
// (RQ16) back-end link uses 32 data bits and no dma signals
// (RQ17) controller shares 40-bit main bus with three user fpgas
// (RQ18) configuration control registers sit in the micro's address space
// (RQ19) after own configuration the controller resets the board micro
// (RQ20) user configuration resets held inactive until controller configured; the code holds them low (asserted) until cfg_rel is set
// (RQ21) micro polls each temperature sensor about once per second
// (RQ22) terminal runs 19200 bit/s, no parity, no handshake
// (RQ23) script lines run in file order, each finished before the next
`timescale 1ns/10ps
`default_nettype none
module bcs_script_ctrl #(
	parameter int ADDR_W = 16,
	parameter int MB_W   = 40
) (
	input  wire logic              mclk,               // 20 mhz controller clock
	input  wire logic              rst_n,              // async power-on reset
	input  wire logic              card_present,       // card inserted
	input  wire logic              script_found,       // default root script exists
	output logic                   script_open,        // open request to card reader
	input  wire logic              char_valid,         // script character offered
	input  wire logic [7:0]        char_data,          // script character
	output logic                   char_ready,         // character taken
	input  wire logic              script_eof,         // end of script file
	output logic                   load_start,         // load pulse for user fpga
	output logic [1:0]             load_target,        // 0 a, 1 b, 2 c
	output logic [7:0]             load_name0,         // first filename character
	input  wire logic              header_match,       // bitstream target matches board
	input  wire logic              load_done,          // load finished
	output logic                   error_flash,        // error indicator
	output logic                   synth_start,        // synthesizer write pulse
	output logic [1:0]             synth_sel,          // 0 a, 1 b, 2 c
	output logic [6:0]             synth_n,            // divide value
	output logic [6:0]             synth_m,            // multiply value
	input  wire logic              synth_done,         // synthesizer written
	output logic                   mem_wr,             // controller byte write
	output logic [ADDR_W-1:0]      controller_byte_address, // byte address
	output logic [7:0]             mem_data,           // byte value
	output logic                   mb_wr,              // main-bus write strobe
	output logic [MB_W-1:0]        mb_out,             // 40-bit main-bus lines
	output logic                   mb_out_en,          // main-bus drive enable
	input  wire logic              mb_ack,             // main-bus write taken
	output logic [1:0]             verbosity,          // serial verbosity level
	output logic                   header_check,       // header checking enable
	input  wire logic [2:0]        host_bar,           // host window of access
	input  wire logic              host_access,        // host access present
	output logic                   host_to_ctrl,       // route access to controller
	output logic                   host_to_fpga_a,     // route access to fpga a
	output logic                   backend_own_request,// ask for bridge back-end
	input  wire logic              backend_own_grant,  // back-end granted when low
	output logic                   backend_drive_en,   // drive 32 back-end data bits
	output logic                   micro_reset_n,      // board micro reset
	output logic [2:0]             user_config_reset_n // user fpga config resets
);
	localparam int NIB_W = 64;
	typedef struct packed {
		bcs_pkg::bcs_state_e st;
		bcs_pkg::bcs_cmd_e   cmd;
		logic [5:0]          pos;      // char index within line
		logic [1:0]          field;    // argument field number
		logic [NIB_W-1:0]    acc0;     // first hex/decimal argument
		logic [NIB_W-1:0]    acc1;     // second argument
		logic [1:0]          tgt;
		logic [7:0]          name0;
		logic                second;   // last char was a separator
		logic [1:0]          verb;
		logic                chk;
		logic                err;
		logic                open;
		logic [1:0]          go;       // 1 load, 2 synth, 3 bus
		logic                mwr;
		logic                mbw;
		logic [4:0]          mrst;
		logic                own_req;
		logic                cfg_rel;
	} bcs_s;
	bcs_s q_r, q_nxt;

	// the parser and the bus packing serve only these widths
	if (ADDR_W != 16 || MB_W != 40) begin : g_width_check
		$error("bcs_script_ctrl: unsupported widths");
	end

	function automatic logic [3:0] hexval(input logic [7:0] c);
		if (c >= 8'h61)
			hexval = 4'(c - 8'h57);
		else if (c >= 8'h41)
			hexval = 4'(c - 8'h37);
		else
			hexval = 4'(c - 8'h30);
	endfunction

	function automatic logic [6:0] dec2(input logic [NIB_W-1:0] v);
		// two packed decimal digits, tens in bits 7:4
		dec2 = 7'(v[7:4] * 4'ha + v[3:0]);
	endfunction

	// next-state logic of the whole controller
	always_comb begin
		logic [7:0] c;
		c = char_data;
		q_nxt = q_r;
		q_nxt.go = 2'h0;
		q_nxt.mwr = 1'b0;
		q_nxt.mbw = 1'b0;
		// (RQ19) micro reset pulse after own configuration
		if (q_r.mrst != 5'h0)
			q_nxt.mrst = q_r.mrst - 5'h1;
		case (q_r.st)
			bcs_pkg::BCS_ST_BOOT: begin
				// (RQ20) release user config resets once configured
				q_nxt.cfg_rel = 1'b1;
				if (q_r.mrst == 5'h1) begin
					// (RQ1) open default script when a card holds one
					q_nxt.open = card_present && script_found;
					q_nxt.st = (card_present && script_found) ?
						bcs_pkg::BCS_ST_LINE : bcs_pkg::BCS_ST_DONE;
				end
			end
			bcs_pkg::BCS_ST_LINE: begin
				if (char_valid) begin
					q_nxt.pos = (q_r.pos == 6'h3f) ? q_r.pos : q_r.pos + 6'h1;
					// (RQ2) newline ends the command
					if (c == bcs_pkg::CH_NL) begin
						q_nxt.st = bcs_pkg::BCS_ST_EXEC;
						// an empty line must not repeat the previous command
						if (q_r.pos == 6'h0)
							q_nxt.cmd = bcs_pkg::BCS_CMD_NONE;
					end else if (q_r.pos == 6'h0) begin
						// a new line starts with empty arguments
						q_nxt.acc0 = '0;
						q_nxt.acc1 = '0;
						// (RQ3) comment lines are marked and skipped
						case (c)
							bcs_pkg::CH_SLASH: q_nxt.cmd = bcs_pkg::BCS_CMD_NOTE;
							8'h46: q_nxt.cmd = bcs_pkg::BCS_CMD_LOAD;
							8'h43: q_nxt.cmd = bcs_pkg::BCS_CMD_CLK;
							8'h53: q_nxt.cmd = bcs_pkg::BCS_CMD_CHECK;
							8'h56: q_nxt.cmd = bcs_pkg::BCS_CMD_VERB;
							8'h4d: q_nxt.cmd = bcs_pkg::BCS_CMD_MEM;
							8'h50: q_nxt.cmd = bcs_pkg::BCS_CMD_PORT;
							default: q_nxt.cmd = bcs_pkg::BCS_CMD_NONE;
						endcase
					end else if (q_r.pos == 6'h1 && q_r.cmd == bcs_pkg::BCS_CMD_MEM &&
							c == 8'h41) begin
						q_nxt.cmd = bcs_pkg::BCS_CMD_MBUS; // MAIN versus MEMORY
					end else if (q_r.cmd != bcs_pkg::BCS_CMD_NOTE && c != bcs_pkg::CH_CR) begin
						// a separator marks the start of the next word
						q_nxt.second = (c == bcs_pkg::CH_SPACE || c == bcs_pkg::CH_COLON);
						if (!q_nxt.second) begin
							if (q_r.cmd == bcs_pkg::BCS_CMD_MEM ||
									q_r.cmd == bcs_pkg::BCS_CMD_MBUS) begin
								// 0x opens a hex field, its digits follow with no gap
								if (c == bcs_pkg::CH_X || c == bcs_pkg::CH_XU)
									q_nxt.field = q_r.field + 2'h1;
								else if (!q_r.second && q_r.field == 2'h1)
									q_nxt.acc0 = {q_r.acc0[NIB_W-5:0], hexval(c)};
								else if (!q_r.second && q_r.field == 2'h2)
									q_nxt.acc1 = {q_r.acc1[NIB_W-5:0], hexval(c)};
							end else if (q_r.cmd == bcs_pkg::BCS_CMD_CLK) begin
								// N, M and the clock letter count only at a word start
								if (q_r.second && (c == 8'h4e || c == 8'h4d))
									q_nxt.field = (c == 8'h4e) ? 2'h1 : 2'h2;
								else if (q_r.second && q_r.field == 2'h0 &&
										c >= 8'h41 && c <= 8'h43)
									q_nxt.tgt = 2'(c - 8'h41);
								else if (c >= 8'h30 && c <= 8'h39 && q_r.field == 2'h1)
									q_nxt.acc0 = {q_r.acc0[NIB_W-5:0], hexval(c)};
								else if (c >= 8'h30 && c <= 8'h39 && q_r.field == 2'h2)
									q_nxt.acc1 = {q_r.acc1[NIB_W-5:0], hexval(c)};
							end else if (q_r.cmd == bcs_pkg::BCS_CMD_LOAD) begin
								if (q_r.second && q_r.field == 2'h0 &&
										c >= 8'h41 && c <= 8'h43) begin
									q_nxt.tgt = 2'(c - 8'h41);
									q_nxt.field = 2'h1;
								end else if (q_r.second && q_r.field == 2'h1) begin
									q_nxt.name0 = c;
									q_nxt.field = 2'h2;
								end
							end else begin
								// level, yes/no and port words: the last char counts
								q_nxt.acc1 = {q_r.acc1[NIB_W-5:0], hexval(c)};
							end
						end
					end
				end else if (script_eof) begin
					q_nxt.st = bcs_pkg::BCS_ST_DONE;
				end
			end
			bcs_pkg::BCS_ST_EXEC: begin
				q_nxt.st = bcs_pkg::BCS_ST_LINE;
				case (q_r.cmd)
					bcs_pkg::BCS_CMD_VERB: begin
						// (RQ4) levels 0..3 only
						if (q_r.acc1[3:0] <= 4'h3)
							q_nxt.verb = q_r.acc1[1:0];
					end
					bcs_pkg::BCS_CMD_CHECK: begin
						// (RQ6) y enables header checking
						q_nxt.chk = (q_r.acc1[3:0] == hexval(8'h79));
					end
					bcs_pkg::BCS_CMD_LOAD: begin
						// (RQ5) start load of the named fpga
						q_nxt.go = 2'h1;
						q_nxt.st = bcs_pkg::BCS_ST_WAIT;
					end
					bcs_pkg::BCS_CMD_CLK: begin
						// (RQ8) zero arguments are refused
						if (dec2(q_r.acc0) != 7'h0 && dec2(q_r.acc1) != 7'h0) begin
							// (RQ7) program chosen synthesizer
							q_nxt.go = 2'h2;
							q_nxt.st = bcs_pkg::BCS_ST_WAIT;
						end
					end
					bcs_pkg::BCS_CMD_MEM: begin
						// (RQ11) single byte write
						q_nxt.mwr = 1'b1;
					end
					bcs_pkg::BCS_CMD_MBUS: begin
						// (RQ15) ask for the shared path before writing
						q_nxt.own_req = 1'b1;
						q_nxt.go = 2'h3;
						q_nxt.st = bcs_pkg::BCS_ST_WAIT;
					end
					// (RQ13) port commands do nothing for any port number, port 1 included
					default: ;
				endcase
				q_nxt.pos = 6'h0;
				q_nxt.field = 2'h0;
				q_nxt.second = 1'b0;
			end
			bcs_pkg::BCS_ST_WAIT: begin
				// (RQ23) hold the script until the command finishes
				if (q_r.cmd == bcs_pkg::BCS_CMD_LOAD && load_done) begin
					// (RQ6) with header checking on, a mismatch flashes the error indicator
					if (q_r.chk && !header_match)
						q_nxt.err = 1'b1;
					q_nxt.st = bcs_pkg::BCS_ST_LINE;
				end else if (q_r.cmd == bcs_pkg::BCS_CMD_CLK && synth_done) begin
					q_nxt.st = bcs_pkg::BCS_ST_LINE;
				end else if (q_r.cmd == bcs_pkg::BCS_CMD_MBUS && q_r.own_req &&
						(q_r.mbw || backend_own_grant == 1'b0)) begin
					// (RQ12) one main-bus write, started while ours, held until taken
					q_nxt.mbw = ~mb_ack;
					if (mb_ack) begin
						q_nxt.own_req = 1'b0;
						q_nxt.st = bcs_pkg::BCS_ST_LINE;
					end
				end
			end
			bcs_pkg::BCS_ST_DONE: ;
			default: q_nxt.st = bcs_pkg::BCS_ST_BOOT;
		endcase
	end

	// state register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q_r <= '0;
			q_r.st <= bcs_pkg::BCS_ST_BOOT;
			q_r.verb <= bcs_pkg::VERB_RST;
			q_r.chk <= bcs_pkg::CHECK_RST;
			q_r.mrst <= 5'(bcs_pkg::MRST_CYC + 1);
		end else begin
			q_r <= q_nxt;
		end
	end

	// outputs
	assign script_open = q_r.open;
	assign char_ready = (q_r.st == bcs_pkg::BCS_ST_LINE);
	assign load_start = (q_r.go == 2'h1);
	assign load_target = q_r.tgt;
	assign load_name0 = q_r.name0;
	assign error_flash = q_r.err;
	assign synth_start = (q_r.go == 2'h2);
	assign synth_sel = q_r.tgt;
	// (RQ10) synthesizer references fixed by the board clocks
	assign synth_n = dec2(q_r.acc0);
	assign synth_m = dec2(q_r.acc1);
	// (RQ18) byte writes land in the micro's address space
	assign mem_wr = q_r.mwr;
	assign controller_byte_address = q_r.acc0[ADDR_W-1:0];
	assign mem_data = q_r.acc1[7:0];
	assign mb_wr = q_r.mbw;
	// (RQ17) address then data share the 40-bit bus
	assign mb_out = {q_r.acc0[7:0], q_r.acc1[31:0]};
	assign mb_out_en = q_r.mbw;
	assign verbosity = q_r.verb;
	assign header_check = q_r.chk;
	// (RQ14) window 0 to controller, others to fpga a
	assign host_to_ctrl = host_access && (host_bar == 3'h0);
	assign host_to_fpga_a = host_access && (host_bar != 3'h0);
	assign backend_own_request = q_r.own_req;
	// (RQ16) only 32 data bits driven, never while fpga a owns it
	assign backend_drive_en = q_r.own_req && !backend_own_grant;
	// (RQ21) the micro, once released, runs its own sensor polling
	// (RQ19) micro held in reset for a short pulse after start
	assign micro_reset_n = (q_r.mrst == 5'h0);
	// (RQ20) user config resets stay low (asserted) until released
	assign user_config_reset_n = {3{q_r.cfg_rel}};
endmodule
`default_nettype wire

/* File: bench/bcs_script_ctrl_properties.sv */
// assertions on the script controller ports
`timescale 1ns/10ps
`default_nettype none
module bcs_script_ctrl_properties (
	input wire logic       mclk,                // clock
	input wire logic       rst_n,               // reset
	input wire logic       card_present,        // card in
	input wire logic       script_found,        // script there
	input wire logic       script_open,         // script open
	input wire logic       char_ready,          // char taken
	input wire logic       load_start,          // load pulse
	input wire logic       header_match,        // header fits
	input wire logic       load_done,           // load over
	input wire logic       error_flash,         // error lamp
	input wire logic       synth_start,         // synth pulse
	input wire logic [6:0] synth_n,             // divide
	input wire logic [6:0] synth_m,             // multiply
	input wire logic       mb_wr,               // bus write
	input wire logic       mb_out_en,           // bus drive
	input wire logic       mb_ack,              // bus taken
	input wire logic       header_check,        // check on
	input wire logic [2:0] host_bar,            // window
	input wire logic       host_access,         // access
	input wire logic       host_to_ctrl,        // to controller
	input wire logic       host_to_fpga_a,      // to fpga a
	input wire logic       backend_own_request, // ask back-end
	input wire logic       backend_own_grant,   // grant, low
	input wire logic       backend_drive_en,    // drive back-end
	input wire logic       micro_reset_n,       // micro reset
	input wire logic [2:0] user_config_reset_n  // config resets
);
	logic [7:0] cyc_r;
	logic       load_busy_r;
	// cycles since reset release, saturating
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_r <= 8'h00;
		end else if (cyc_r != 8'hff) begin
			cyc_r <= cyc_r + 8'h01;
		end
	end
	// a load is open from its start pulse until its done pulse
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			load_busy_r <= 1'b0;
		end else if (load_done) begin
			load_busy_r <= 1'b0;
		end else if (load_start) begin
			load_busy_r <= 1'b1;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_route_ctrl; host_to_ctrl == (host_access && host_bar == 3'h0); endproperty
	a_route_ctrl: assert property (p_route_ctrl) else $error("window zero misrouted");
	property p_route_fpga; host_to_fpga_a == (host_access && host_bar != 3'h0); endproperty
	a_route_fpga: assert property (p_route_fpga) else $error("upper window misrouted");
	property p_backend_excl; backend_drive_en |-> backend_own_request && !backend_own_grant; endproperty
	a_backend_excl: assert property (p_backend_excl) else $error("back-end driven unowned");
	property p_micro_hold; cyc_r < 8'h10 |-> !micro_reset_n; endproperty
	a_micro_hold: assert property (p_micro_hold) else $error("micro reset too short");
	property p_micro_free; cyc_r > 8'h28 |-> micro_reset_n; endproperty
	a_micro_free: assert property (p_micro_free) else $error("micro reset stuck");
	property p_cfg_release; cyc_r > 8'h01 |-> user_config_reset_n == 3'h7; endproperty
	a_cfg_release: assert property (p_cfg_release) else $error("config reset held");
	property p_open; cyc_r == 8'h3c && card_present && script_found |-> script_open; endproperty
	a_open: assert property (p_open) else $error("script not opened");
	property p_load_order; (load_start || load_busy_r) |-> !char_ready; endproperty
	a_load_order: assert property (p_load_order) else $error("line read during load");
	property p_reject; load_done && header_check && !header_match |-> ##[1:2] error_flash; endproperty
	a_reject: assert property (p_reject) else $error("bad header not flagged");
	property p_mb_hold; mb_wr && !mb_ack |=> mb_wr && mb_out_en; endproperty
	a_mb_hold: assert property (p_mb_hold) else $error("bus write dropped early");
	// zero arguments never reach the synthesizer
	property p_synth_args; synth_start |-> synth_n != 7'h0 && synth_m != 7'h0; endproperty
	a_synth_args: assert property (p_synth_args) else $error("zero synthesizer argument");
endmodule
bind bcs_script_ctrl bcs_script_ctrl_properties props_u (.*);
`default_nettype wire

/* File: bench/bcs_card_model.sv */
// card model serving the script one character at a time
`timescale 1ns/10ps
`default_nettype none
module bcs_card_model (
	input  wire logic       mclk,        // clock
	input  wire logic       rst_n,       // reset
	input  wire logic       script_open, // script open
	input  wire logic       char_ready,  // char taken
	output logic            char_valid,  // char offered
	output logic [7:0]      char_data,   // char value
	output logic            script_eof   // file over
);
	logic [7:0] q[$];
	int         tick;
	task automatic add_line(input string s);
		foreach (s[i]) q.push_back(s[i]);
		q.push_back(8'h0a);
	endtask
	// offer chars with stalls; an idle data bus shows the inverse of the last char
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			char_valid <= 1'b0;
			char_data  <= 8'h00;
			script_eof <= 1'b0;
			tick       <= 0;
		end else begin
			tick <= tick + 1;
			if (char_valid && char_ready) begin
				void'(q.pop_front());
				char_valid <= 1'b0;
				char_data  <= ~char_data;
			end else if (!char_valid && script_open && q.size() > 0 && tick % 3 != 0) begin
				char_valid <= 1'b1;
				char_data  <= q[0];
			end
			script_eof <= script_open && q.size() == 0;
		end
	end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench of the script controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        mclk = 1'b0, rst_n = 1'b0, card_present = 1'b1, script_found = 1'b1;
	logic        header_match = 1'b0, load_done = 1'b0, synth_done = 1'b0, mb_ack = 1'b0;
	logic        host_access = 1'b0, backend_own_grant = 1'b1, mb_q = 1'b0;
	logic        pend_l = 1'b0, pend_s = 1'b0, pend_m = 1'b0;
	logic [2:0]  host_bar = 3'h0;
	logic        script_open, char_valid, char_ready, script_eof, load_start, error_flash;
	logic        synth_start, mem_wr, mb_wr, mb_out_en, header_check, host_to_ctrl;
	logic        host_to_fpga_a, backend_own_request, backend_drive_en, micro_reset_n;
	logic [1:0]  load_target, synth_sel, verbosity;
	logic [2:0]  user_config_reset_n;
	logic [6:0]  synth_n, synth_m;
	logic [7:0]  char_data, load_name0, mem_data;
	logic [15:0] controller_byte_address;
	logic [39:0] mb_out;
	logic [47:0] exp_q[$];
	logic [31:0] seed = 32'h211891fa;
	int          n_mismatch = 0, samples_checked = 0, wait_c = 0, cycles = 0;

	bcs_script_ctrl dut_u (.*);
	bcs_card_model card_u (.*);

	// clock generator
	initial begin
		forever #25 mclk = ~mclk;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [47:0] got, input logic [47:0] want);
		samples_checked++;
		if (got !== want) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	task automatic take(input logic [47:0] got);
		if (exp_q.size() == 0) chk(got, 48'h0);
		else chk(got, exp_q.pop_front());
	endtask
	task automatic line(input string s, input logic [47:0] e);
		card_u.add_line(s);
		if (e !== 48'h0) exp_q.push_back(e);
	endtask
	task automatic end_sim();
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// far side answers after a random delay; random host traffic meanwhile
	always @(posedge mclk) begin
		host_bar          <= 3'(rnd() >> 29);
		host_access       <= rnd() > 32'h7fffffff;
		backend_own_grant <= rnd() > 32'h7fffffff;
		// only the files for fpga a carry a fitting header
		header_match      <= load_target == 2'h0;
		load_done         <= wait_c == 1 && pend_l;
		synth_done        <= wait_c == 1 && pend_s;
		mb_ack            <= wait_c == 1 && pend_m;
		if (wait_c > 0) begin
			wait_c <= wait_c - 1;
		end else if (load_start || synth_start || (mb_wr && !mb_ack)) begin
			wait_c <= 2 + int'(rnd() & 32'h3);
			pend_l <= load_start;
			pend_s <= synth_start;
			pend_m <= mb_wr;
		end
	end
	// each command seen at the outputs is matched with the oldest note
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		mb_q   <= mb_wr;
		chk({46'h0, host_to_ctrl, host_to_fpga_a},
			{46'h0, host_access && host_bar == 3'h0, host_access && host_bar != 3'h0});
		if (cycles == 8000) begin
			n_mismatch++;
			end_sim();
		end
		if (rst_n && load_start) take({4'h2, 33'h0, error_flash, load_target, load_name0});
		if (rst_n && synth_start) take({4'h3, 28'h0, synth_sel, synth_n, synth_m});
		if (rst_n && mem_wr) take({4'h6, 20'h0, controller_byte_address, mem_data});
		if (rst_n && mb_wr && !mb_q) take({4'h7, 4'h0, mb_out});
	end
	// main sequence: the script with its expected commands, then final state
	initial begin
		line("VERBOSE LEVEL: 0", 48'h0);
		line("// FPGA A:x.rbf MAIN BUS 0x1", 48'h0);
		line("SANITY CHECK: n", 48'h0);
		line("FPGA B:b.rbf", {4'h2, 34'h0, 2'h1, "b"});
		line("FPGA A:a.rbf", {4'h2, 34'h0, 2'h0, "a"});
		line("SANITY CHECK: y", 48'h0);
		line("FPGA A:a.rbf", {4'h2, 34'h0, 2'h0, "a"});
		line("FPGA C:c.rbf", {4'h2, 34'h0, 2'h2, "c"});
		line("CLOCK FREQUENCY: A N 99 M 28", {4'h3, 28'h0, 2'h0, 7'h63, 7'h1c});
		line("CLOCK FREQUENCY: B N 7 M 49", {4'h3, 28'h0, 2'h1, 7'h07, 7'h31});
		line("CLOCK FREQUENCY: C N 0 M 16", 48'h0);
		line("CLOCK FREQUENCY: C N 1 M 16", {4'h3, 28'h0, 2'h2, 7'h01, 7'h10});
		line("MEMORY MAPPED 0xDF3C 0xA5", {4'h6, 20'h0, 16'hdf3c, 8'ha5});
		line("", 48'h0);
		line("MAIN BUS 0x000012c4 0xcafe0001", {4'h7, 4'h0, 8'hc4, 32'hcafe0001});
		line("PORT 3", 48'h0);
		line("VERBOSE LEVEL: 5", 48'h0);
		line("MEMORY MAPPED 0x0001 0x00", {4'h6, 20'h0, 16'h0001, 8'h00});
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		chk(48'(verbosity), 48'h3);
		chk(48'(header_check), 48'h1);
		// the script is done once every note is taken and the card is empty
		while (exp_q.size() > 0 || !script_eof) @(posedge mclk);
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		chk(48'(verbosity), 48'h0);
		chk(48'(script_open), 48'h1);
		chk(48'(micro_reset_n), 48'h1);
		chk(48'(user_config_reset_n), 48'h7);
		// the terminal link lies outside this block; only its verbosity shows here
		chk(48'(header_check), 48'h1);
		chk(48'(error_flash), 48'h1);
		end_sim();
	end
endmodule
`default_nettype wire
